// ==== verilog/cycle_scan_counter_blocks.sv ====
// Preset counter, up-down counter and serial-to-parallel converter, AXI4-Lite set-up.
// Assumes asynchronous discrete pins; one aclk edge is one controller cycle.
// Function
// - Down mode: load preset, decrement, done at zero
// - Up mode: start zero, increment, done at preset
// - Auto reset clears count when input OFF
// - Manual reset clears, blocks counting while ON
// - Counting resumes on edge after reset release
// - Start clears counts; ON input not counted
// - Config: down/up, manual/auto, preset 1..65535
// - Up-down counter: up edge adds, down subtracts
// - Up: set-to-zero asserts, zero-to-one clears output
// - Down: below zero asserts, from set clears
// - Simultaneous up and down edges count nothing
// - Up-down manual reset holds zero, output off
// - Converter counts up, wraps 255 to zero
// - Output n is count bit n-1, 1..8 enabled
// - Converter reset forces zero, ignores pulses
//
// The implementer's own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "scan_counter_consts.svh"
module cycle_scan_counter_blocks #(
  parameter int ADDR_W = 8,
  parameter int CNT_W  = 16,
  parameter int SP_W   = 8
) (
  input  logic                    aclk,
  input  logic                    aresetn,
  input  logic [ADDR_W-1:0]       awaddr,
  input  logic [2:0]              awprot,
  input  logic                    awvalid,
  output logic                    awready,
  input  logic [31:0]             wdata,
  input  logic [3:0]              wstrb,
  input  logic                    wvalid,
  output logic                    wready,
  output logic [1:0]              bresp,
  output logic                    bvalid,
  input  logic                    bready,
  input  logic [ADDR_W-1:0]       araddr,
  input  logic [2:0]              arprot,
  input  logic                    arvalid,
  output logic                    arready,
  output logic [31:0]             rdata,
  output logic [1:0]              rresp,
  output logic                    rvalid,
  input  logic                    rready,
  input  scan_counter_pkg::pins_s pins,
  output logic                    preset_done,
  output logic                    ud_done,
  output logic [SP_W-1:0]         sp_out
);
  import scan_counter_pkg::*;

  cfg_s              cfg_reg;
  logic              awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic              aw_full_reg, w_full_reg, wr_fire;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [31:0]       w_data_reg, rdata_reg, rd_word;
  logic [31:0]       ctrl_wr, preset_wr, udset_wr;
  logic [3:0]        w_strb_reg;
  logic [1:0]        bresp_reg, rresp_reg;
  logic              run_d_reg, start, clear;
  pins_s             lvl, rise;
  logic [CNT_W-1:0]  pc_count_reg, pc_init, ud_count_reg;
  logic              pc_out_reg, pc_hold, ud_out_reg;
  logic [SP_W-1:0]   sp_count_reg, sp_out_reg, sp_mask;

  function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
    unique case (a)
      `OFF_CTRL, `OFF_PRESET, `OFF_UD_SET, `OFF_STATUS,
      `OFF_PC_COUNT, `OFF_UD_COUNT, `OFF_SP_COUNT: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) m[8*i +: 8] = nw[8*i +: 8];
    end
    return m;
  endfunction

  // A zero set value would make the completion output meaningless
  function automatic logic [15:0] at_least_one(input logic [15:0] v);
    return (v == 16'h0000) ? 16'h0001 : v;
  endfunction

  function automatic logic [3:0] clamp_points(input logic [3:0] p);
    if (p == 4'h0) return 4'h1;
    if (p > `MAX_POINTS) return `MAX_POINTS;
    return p;
  endfunction

  function automatic logic [31:0] ctrl_word(input cfg_s c);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`CTRL_RUN_BIT] = c.run;
    w[`CTRL_DIR_BIT] = (c.dir == DIR_UP);
    w[`CTRL_AUTO_BIT] = (c.rmode == RST_AUTO);
    w[`CTRL_PTS_MSB:`CTRL_PTS_LSB] = c.points;
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave

  assign wr_fire = aw_full_reg && w_full_reg && !bvalid_reg;

  // Byte-merged write words, one per writable register
  assign ctrl_wr   = merge(ctrl_word(cfg_reg), w_data_reg, w_strb_reg);
  assign preset_wr = merge({16'h0000, cfg_reg.preset}, w_data_reg, w_strb_reg);
  assign udset_wr  = merge({16'h0000, cfg_reg.ud_set}, w_data_reg, w_strb_reg);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b0;
      aw_full_reg <= 1'b0;
      aw_addr_reg <= '0;
    end else if (awvalid && awready_reg) begin
      awready_reg <= 1'b0;
      aw_full_reg <= 1'b1;
      aw_addr_reg <= awaddr;
    end else if (wr_fire) begin
      aw_full_reg <= 1'b0;
    end else if (!aw_full_reg && !bvalid_reg) begin
      awready_reg <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_reg <= 1'b0;
      w_full_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end else if (wvalid && wready_reg) begin
      wready_reg <= 1'b0;
      w_full_reg <= 1'b1;
      w_data_reg <= wdata;
      w_strb_reg <= wstrb;
    end else if (wr_fire) begin
      w_full_reg <= 1'b0;
    end else if (!w_full_reg && !bvalid_reg) begin
      wready_reg <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= `RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= addr_hit(aw_addr_reg) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // Configuration; read-only offsets accept the write and keep nothing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_reg.run    <= 1'b0;
      cfg_reg.dir    <= DIR_DOWN;
      cfg_reg.rmode  <= RST_MANUAL;
      cfg_reg.points <= `RST_POINTS;
      cfg_reg.preset <= `RST_PRESET;
      cfg_reg.ud_set <= `RST_UD_SET;
    end else if (wr_fire) begin
      unique case (aw_addr_reg)
        `OFF_CTRL: begin
          cfg_reg.run    <= ctrl_wr[`CTRL_RUN_BIT];
          cfg_reg.dir    <= count_dir_e'(ctrl_wr[`CTRL_DIR_BIT]);
          cfg_reg.rmode  <= reset_mode_e'(ctrl_wr[`CTRL_AUTO_BIT]);
          cfg_reg.points <= clamp_points(ctrl_wr[`CTRL_PTS_MSB:`CTRL_PTS_LSB]);
        end
        `OFF_PRESET: cfg_reg.preset <= at_least_one(preset_wr[15:0]);
        `OFF_UD_SET: cfg_reg.ud_set <= at_least_one(udset_wr[15:0]);
        default: ;
      endcase
    end
  end

  always_comb begin
    unique case (araddr)
      `OFF_CTRL:     rd_word = ctrl_word(cfg_reg);
      `OFF_PRESET:   rd_word = {16'h0000, cfg_reg.preset};
      `OFF_UD_SET:   rd_word = {16'h0000, cfg_reg.ud_set};
      `OFF_STATUS:   rd_word = {16'h0000, sp_out_reg, 6'h00, ud_out_reg, pc_out_reg};
      `OFF_PC_COUNT: rd_word = 32'(pc_count_reg);
      `OFF_UD_COUNT: rd_word = 32'(ud_count_reg);
      `OFF_SP_COUNT: rd_word = 32'(sp_count_reg);
      default:       rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= `RESP_OKAY;
    end else if (arvalid && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rdata_reg   <= rd_word;
      rresp_reg   <= addr_hit(araddr) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid_reg && rready) begin
      rvalid_reg  <= 1'b0;
    end else if (!rvalid_reg) begin
      arready_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input sampling and start of operation

  always_ff @(posedge aclk) begin
    if (!aresetn) run_d_reg <= 1'b0;
    else run_d_reg <= cfg_reg.run;
  end

  assign start = cfg_reg.run && !run_d_reg;
  // Stopped blocks are held cleared so a later start always begins fresh
  assign clear = !cfg_reg.run || start;

  edge_sync #(.W($bits(pins_s))) u_pins (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     (pins),
    .arm     (start),
    .level   (lvl),
    .rise    (rise)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Preset counter

  assign pc_init = (cfg_reg.dir == DIR_UP) ? '0 : CNT_W'(cfg_reg.preset);
  assign pc_hold = (cfg_reg.rmode == RST_MANUAL) ? lvl.cnt_rst : !lvl.cnt_in;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc_count_reg <= '0;
      pc_out_reg   <= 1'b0;
    end else if (clear || pc_hold) begin
      pc_count_reg <= pc_init;
      pc_out_reg   <= 1'b0;
    end else if (rise.cnt_in) begin
      if (cfg_reg.dir == DIR_DOWN && pc_count_reg != '0) begin
        pc_count_reg <= pc_count_reg - 1'b1;
        pc_out_reg   <= (pc_count_reg == CNT_W'(1));
      end else if (cfg_reg.dir == DIR_UP && pc_count_reg != CNT_W'(cfg_reg.preset)) begin
        pc_count_reg <= pc_count_reg + 1'b1;
        pc_out_reg   <= (pc_count_reg + 1'b1 == CNT_W'(cfg_reg.preset));
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Up-down counter; the source must hold each level over one cycle

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ud_count_reg <= '0;
      ud_out_reg   <= 1'b0;
    end else if (clear || lvl.ud_rst) begin
      ud_count_reg <= '0;
      ud_out_reg   <= 1'b0;
    end else if (rise.ud_up && !rise.ud_down) begin
      if (ud_count_reg == CNT_W'(cfg_reg.ud_set)) begin
        ud_count_reg <= '0;
        ud_out_reg   <= 1'b1;
      end else begin
        ud_count_reg <= ud_count_reg + 1'b1;
        if (ud_count_reg == '0) ud_out_reg <= 1'b0;
      end
    end else if (rise.ud_down && !rise.ud_up) begin
      if (ud_count_reg == '0) begin
        ud_count_reg <= CNT_W'(cfg_reg.ud_set);
        ud_out_reg   <= 1'b1;
      end else begin
        if (ud_count_reg == CNT_W'(cfg_reg.ud_set)) ud_out_reg <= 1'b0;
        ud_count_reg <= ud_count_reg - 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial-to-parallel converter

  always_comb begin
    for (int i = 0; i < SP_W; i++) begin
      sp_mask[i] = (i < int'(cfg_reg.points));
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || clear || lvl.sp_rst) begin
      sp_count_reg <= '0;
    end else if (rise.sp_in) begin
      sp_count_reg <= sp_count_reg + 1'b1;  // natural wrap 255 to 0
    end
  end

  // Output follows the count one edge later, masked by enabled points
  always_ff @(posedge aclk) begin
    if (!aresetn) sp_out_reg <= '0;
    else sp_out_reg <= sp_count_reg & sp_mask;
  end

  assign awready     = awready_reg;
  assign wready      = wready_reg;
  assign bvalid      = bvalid_reg;
  assign bresp       = bresp_reg;
  assign arready     = arready_reg;
  assign rvalid      = rvalid_reg;
  assign rdata       = rdata_reg;
  assign rresp       = rresp_reg;
  assign preset_done = pc_out_reg;
  assign ud_done     = ud_out_reg;
  assign sp_out      = sp_out_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_pc_down;
    !clear && !pc_hold && cfg_reg.dir == DIR_DOWN && rise.cnt_in && pc_count_reg != '0
      |=> pc_count_reg == $past(pc_count_reg) - 1'b1 && pc_out_reg == (pc_count_reg == '0);
  endproperty
  a_pc_down: assert property (p_pc_down) else $error("down count step wrong");

  property p_pc_up;
    !clear && !pc_hold && cfg_reg.dir == DIR_UP && rise.cnt_in
      && pc_count_reg != CNT_W'(cfg_reg.preset)
      |=> pc_count_reg == $past(pc_count_reg) + 1'b1
          && pc_out_reg == (pc_count_reg == CNT_W'($past(cfg_reg.preset)));
  endproperty
  a_pc_up: assert property (p_pc_up) else $error("up count step wrong");

  property p_pc_auto;
    !clear && cfg_reg.rmode == RST_AUTO && !lvl.cnt_in
      |=> !pc_out_reg && pc_count_reg == $past(pc_init);
  endproperty
  a_pc_auto: assert property (p_pc_auto) else $error("auto reset failed");

  property p_pc_manual;
    cfg_reg.rmode == RST_MANUAL && lvl.cnt_rst && rise.cnt_in
      |=> !pc_out_reg && pc_count_reg == $past(pc_init);
  endproperty
  a_pc_manual: assert property (p_pc_manual) else $error("manual reset lost");

  property p_start;
    start |=> rise == '0 && pc_count_reg == $past(pc_init)
              && ud_count_reg == '0 && sp_count_reg == '0;
  endproperty
  a_start: assert property (p_start) else $error("start did not clear");

  property p_ud_step;
    !clear && !lvl.ud_rst && rise.ud_up && !rise.ud_down
      && ud_count_reg != CNT_W'(cfg_reg.ud_set)
      |=> ud_count_reg == $past(ud_count_reg) + 1'b1;
  endproperty
  a_ud_step: assert property (p_ud_step) else $error("up-down step wrong");

  property p_ud_wrap;
    !clear && !lvl.ud_rst && rise.ud_up && !rise.ud_down
      && ud_count_reg == CNT_W'(cfg_reg.ud_set) |=> ud_count_reg == '0 && ud_out_reg;
  endproperty
  a_ud_wrap: assert property (p_ud_wrap) else $error("up wrap wrong");

  property p_ud_under;
    !clear && !lvl.ud_rst && rise.ud_down && !rise.ud_up && ud_count_reg == '0
      |=> ud_count_reg == CNT_W'($past(cfg_reg.ud_set)) && ud_out_reg;
  endproperty
  a_ud_under: assert property (p_ud_under) else $error("underflow wrong");

  property p_ud_both;
    !clear && !lvl.ud_rst && rise.ud_up && rise.ud_down
      |=> $stable(ud_count_reg) && $stable(ud_out_reg);
  endproperty
  a_ud_both: assert property (p_ud_both) else $error("double edge counted");

  property p_ud_rst;
    lvl.ud_rst |=> ud_count_reg == '0 && !ud_out_reg;
  endproperty
  a_ud_rst: assert property (p_ud_rst) else $error("up-down reset failed");

  property p_sp_wrap;
    !clear && !lvl.sp_rst && rise.sp_in && sp_count_reg == `SP_MAX |=> sp_count_reg == '0;
  endproperty
  a_sp_wrap: assert property (p_sp_wrap) else $error("converter wrap wrong");

  property p_sp_out;
    ##1 sp_out_reg == ($past(sp_count_reg) & $past(sp_mask));
  endproperty
  a_sp_out: assert property (p_sp_out) else $error("parallel output wrong");

  property p_sp_rst;
    lvl.sp_rst ##1 lvl.sp_rst |-> sp_count_reg == '0 ##1 sp_out_reg == '0;
  endproperty
  a_sp_rst: assert property (p_sp_rst) else $error("converter reset failed");

  c_pc_done:  cover property (!pc_out_reg ##1 pc_out_reg);
  c_ud_wrap:  cover property (!ud_out_reg ##1 ud_out_reg ##1 !ud_out_reg);
  c_sp_wrap:  cover property (sp_count_reg == `SP_MAX ##1 sp_count_reg == '0);
  c_axi_wr:   cover property (wr_fire ##1 bvalid_reg);

endmodule

// ==== verilog/scan_counter_consts.svh ====
// Register offsets, field positions and reset values of the scan counters.
// Assumes inclusion by bare name from the counter design files.
`ifndef SCAN_COUNTER_CONSTS_SVH
`define SCAN_COUNTER_CONSTS_SVH

`define OFF_CTRL      8'h00
`define OFF_PRESET    8'h04
`define OFF_UD_SET    8'h08
`define OFF_STATUS    8'h0C
`define OFF_PC_COUNT  8'h10
`define OFF_UD_COUNT  8'h14
`define OFF_SP_COUNT  8'h18

`define CTRL_RUN_BIT  0
`define CTRL_DIR_BIT  1
`define CTRL_AUTO_BIT 2
`define CTRL_PTS_LSB  8
`define CTRL_PTS_MSB  11

`define RST_PRESET    16'h0001
`define RST_UD_SET    16'h0001
`define RST_POINTS    4'h8
`define MAX_POINTS    4'h8
`define SP_MAX        8'hFF

`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2

`endif

// ==== verilog/scan_counter_pkg.sv ====
// Types shared by the scan counter blocks.
// Assumes nothing beyond a SystemVerilog compiler.
package scan_counter_pkg;

  typedef enum logic {DIR_DOWN, DIR_UP} count_dir_e;
  typedef enum logic {RST_MANUAL, RST_AUTO} reset_mode_e;

  typedef struct packed {
    logic        run;
    count_dir_e  dir;
    reset_mode_e rmode;
    logic [3:0]  points;
    logic [15:0] preset;
    logic [15:0] ud_set;
  } cfg_s;

  typedef struct packed {
    logic cnt_in;
    logic cnt_rst;
    logic ud_up;
    logic ud_down;
    logic ud_rst;
    logic sp_in;
    logic sp_rst;
  } pins_s;

endpackage

// ==== verilog/edge_sync.sv ====
// Two-stage synchroniser and rising-edge detector for discrete inputs.
// Assumes asynchronous pins; arm makes every currently-high input look old.
`timescale 1ns/100ps
module edge_sync #(
  parameter int W = 1
) (
  input  logic         aclk,
  input  logic         aresetn,
  input  logic [W-1:0] din,
  input  logic         arm,
  output logic [W-1:0] level,
  output logic [W-1:0] rise
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;
  logic [W-1:0] prev_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= din;
      sync_reg <= meta_reg;
    end
  end

  // Previous-cycle sample; forced high at start so a level already ON is never counted
  always_ff @(posedge aclk) begin
    if (!aresetn || arm) begin
      prev_reg <= '1;
    end else begin
      prev_reg <= sync_reg;
    end
  end

  assign level = sync_reg;
  assign rise  = sync_reg & ~prev_reg;

endmodule

// ==== testbench/pin_source.sv ====
// Discrete input source standing in for the field wiring of the scan counters.
// Assumes the bench sets want just after a clock edge and then waits for settled.
`timescale 1ns/100ps
module pin_source #(
  parameter int HOLD = 6
) (
  input  logic                    aclk,
  input  scan_counter_pkg::pins_s want,
  output scan_counter_pkg::pins_s pins,
  output logic                    settled
);
  import scan_counter_pkg::*;
  int age;
  initial begin
    pins = '0;
    age  = 0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // A new level waits until every pin has held its old one for HOLD cycles,
  // so no ON or OFF phase is shorter than the synchroniser can see
  always @(posedge aclk) begin
    if (pins != want && age >= HOLD) begin
      pins <= want;
      age  <= 0;
    end else if (age < HOLD) begin
      age <= age + 1;
    end
  end
  assign settled = (pins == want) && (age >= HOLD);
endmodule

// ==== testbench/testbench.sv ====
// Self-checking bench for the preset, up-down and serial-to-parallel counters.
// Assumes pin_source drives the pins and AXI4-Lite is the only set-up path.
`timescale 1ns/100ps
`include "scan_counter_consts.svh"
module testbench;
  import scan_counter_pkg::*;
  localparam logic [6:0] CNT = 7'h40, CNR = 7'h20, UP = 7'h10, DN = 7'h08;
  localparam logic [6:0] UDR = 7'h04, SPI = 7'h02, SPR = 7'h01;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, preset_done, ud_done, settled;
  logic [7:0]  awaddr, araddr, sp_out;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  pins_s       want, pins;
  int          fail_count, tests_run, cycles, ud_c, ud_s;
  logic        ud_d;

  cycle_scan_counter_blocks u_dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .pins(pins), .preset_done(preset_done), .ud_done(ud_done),
    .sp_out(sp_out));
  pin_source u_src (.aclk(aclk), .want(want), .pins(pins), .settled(settled));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("mismatches %0d comparisons %0d", fail_count, tests_run);
    if (fail_count == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Hang guard: the whole sequence needs well under a quarter of this
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      fail_count = fail_count + 1;
      $display("[FAIL] %0t run did not finish", $time);
      close_out();
    end
  end
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t response got %h expected %h", $time, got, exp);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok  = 1'b0;
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    chk_resp(r, `RESP_OKAY);
  endtask
  task automatic expect_reg(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(a, d, r);
    chk_resp(r, `RESP_OKAY);
    chk_word(d, e, "register");
  endtask
  // Restart: run low then high, since only the rising run bit starts operation
  task automatic start(input logic [31:0] c);
    wr(`OFF_CTRL, c);
    wr(`OFF_CTRL, c | 32'h0000_0001);
  endtask
  task automatic set_pins(input logic [6:0] v);
    want <= pins_s'(v);
    do @(posedge aclk); while (!settled);
  endtask
  task automatic pulse(input logic [6:0] m);
    set_pins(want | m);
    set_pins(want & ~m);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Reference up-down counter: 0 up, 1 down, 2 both at once
  function automatic void ud_step(input int op);
    if (op == 0) begin
      ud_d = (ud_c == ud_s) ? 1'b1 : (ud_c == 0) ? 1'b0 : ud_d;
      ud_c = (ud_c == ud_s) ? 0 : ud_c + 1;
    end else if (op == 1) begin
      ud_d = (ud_c == 0) ? 1'b1 : (ud_c == ud_s) ? 1'b0 : ud_d;
      ud_c = (ud_c == 0) ? ud_s : ud_c - 1;
    end
  endfunction
  function automatic logic [7:0] sp_mask(input int p);
    return 8'hFF >> (8 - p);
  endfunction
  task automatic ud_do(input int op);
    pulse(op == 0 ? UP : op == 1 ? DN : UP | DN);
    ud_step(op);
    expect_reg(`OFF_UD_COUNT, 32'(ud_c));
    chk_word(32'(ud_done), 32'(ud_d), "ud done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    int          p;
    int          c;
    logic [31:0] v;
    logic [1:0]  r;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    want = '0;
    {fail_count, tests_run, cycles} = '0;
    aresetn = 1'b0;
    void'($urandom(31395));
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    expect_reg(`OFF_CTRL, 32'h0000_0800);
    expect_reg(`OFF_PRESET, 32'h0000_0001);
    wr(`OFF_PRESET, 32'h0000_FFFF);
    expect_reg(`OFF_PRESET, 32'h0000_FFFF);
    wr(`OFF_PRESET, 32'h0000_0000);
    expect_reg(`OFF_PRESET, 32'h0000_0001);
    expect_reg(`OFF_UD_SET, 32'h0000_0001);
    axi_rd(8'h40, v, r);
    chk_resp(r, `RESP_SLVERR);
    chk_word(v, 32'h0000_0000, "unmapped read");
    axi_wr(8'h44, 32'h0000_0003, r);
    chk_resp(r, `RESP_SLVERR);
    // Down counting from a random preset, then a manual clear
    p = $urandom_range(2, 6);
    wr(`OFF_PRESET, 32'(p));
    start(32'h0000_0800);
    expect_reg(`OFF_PC_COUNT, 32'(p));
    for (c = 1; c <= p; c++) begin
      pulse(CNT);
      expect_reg(`OFF_PC_COUNT, 32'(p - c));
      chk_word(32'(preset_done), 32'(c == p), "preset done");
    end
    set_pins(want | CNR);
    chk_word(32'(preset_done), 32'h0000_0000, "preset done");
    set_pins(want & ~CNR);
    // Up counting, clear held while reset is ON, then resume
    start(32'h0000_0802);
    expect_reg(`OFF_PC_COUNT, 32'h0000_0000);
    for (c = 1; c <= p; c++) begin
      pulse(CNT);
      expect_reg(`OFF_PC_COUNT, 32'(c));
      chk_word(32'(preset_done), 32'(c == p), "preset done");
    end
    set_pins(want | CNR);
    pulse(CNT);
    expect_reg(`OFF_PC_COUNT, 32'h0000_0000);
    chk_word(32'(preset_done), 32'h0000_0000, "preset done");
    set_pins(want & ~CNR);
    pulse(CNT);
    expect_reg(`OFF_PC_COUNT, 32'h0000_0001);
    // Input already ON at start is not counted
    set_pins(want | CNT);
    start(32'h0000_0802);
    expect_reg(`OFF_PC_COUNT, 32'h0000_0000);
    set_pins(want & ~CNT);
    expect_reg(`OFF_PC_COUNT, 32'h0000_0000);
    pulse(CNT);
    expect_reg(`OFF_PC_COUNT, 32'h0000_0001);
    // Automatic reset: output stays until the input drops
    wr(`OFF_PRESET, 32'h0000_0001);
    start(32'h0000_0806);
    set_pins(want | CNT);
    repeat (20) @(posedge aclk);
    chk_word(32'(preset_done), 32'h0000_0001, "preset done");
    expect_reg(`OFF_STATUS, 32'h0000_0001);
    set_pins(want & ~CNT);
    chk_word(32'(preset_done), 32'h0000_0000, "preset done");
    expect_reg(`OFF_PC_COUNT, 32'h0000_0000);
    // Up-down: hand-written wraps first, then a random mix
    ud_s = $urandom_range(2, 4);
    {ud_c, ud_d} = '0;
    wr(`OFF_UD_SET, 32'(ud_s));
    start(32'h0000_0800);
    repeat (ud_s + 2) ud_do(0);
    repeat (3) ud_do(1);
    ud_do(2);
    repeat (24) ud_do($urandom_range(0, 2));
    set_pins(want | UDR);
    pulse(UP);
    expect_reg(`OFF_UD_COUNT, 32'h0000_0000);
    chk_word(32'(ud_done), 32'h0000_0000, "ud done");
    set_pins(want & ~UDR);
    pulse(UP);
    expect_reg(`OFF_UD_COUNT, 32'h0000_0001);
    // Converter: full wrap, output points, reset
    start(32'h0000_0800);
    repeat (255) pulse(SPI);
    chk_word(32'(sp_out), 32'h0000_00FF, "sp out");
    pulse(SPI);
    expect_reg(`OFF_SP_COUNT, 32'h0000_0000);
    c = $urandom_range(3, 40);
    repeat (c) pulse(SPI);
    for (p = 1; p <= 8; p++) begin
      wr(`OFF_CTRL, 32'h0000_0001 | 32'(p << 8));
      repeat (3) @(posedge aclk);
      chk_word(32'(sp_out), 32'(8'(c) & sp_mask(p)), "sp out");
    end
    wr(`OFF_CTRL, 32'h0000_0001);
    expect_reg(`OFF_CTRL, 32'h0000_0101);
    wr(`OFF_CTRL, 32'h0000_0F01);
    expect_reg(`OFF_CTRL, 32'h0000_0801);
    set_pins(want | SPR);
    pulse(SPI);
    expect_reg(`OFF_SP_COUNT, 32'h0000_0000);
    set_pins(want & ~SPR);
    pulse(SPI);
    expect_reg(`OFF_SP_COUNT, 32'h0000_0001);
    close_out();
  end
endmodule
